// [hw/lfsc_pkg.sv]
// constants and types of the frame security coder
package lfsc_pkg;

    // ==================================================
    // frame layout
    localparam logic [7:0] DL_VERSION = 8'h00;
    localparam int HDR_LEN = 4;
    localparam int PAYLOAD_LEN = 210;
    localparam int TAG_BYTES = 4;
    localparam int BLK_BYTES = 16;

    // ==================================================
    // counter block fields
    localparam logic [7:0] STUFF_BYTE = 8'h00;
    localparam logic [47:0] DL_ZERO_PAD = 48'h000000000000;
    localparam logic [31:0] CTR_INIT = 32'h00000000;
    localparam logic [31:0] CTR_STEP = 32'h00000001;

    // ==================================================
    // cmac constants
    localparam logic [7:0] CMAC_RB = 8'h87;
    localparam logic [7:0] CMAC_PAD = 8'h80;

    // ==================================================
    // reed-solomon code
    localparam int RS_N = 255;
    localparam int RS_K = 223;
    localparam int RS_PAR = RS_N - RS_K;
    localparam logic [7:0] GF_POLY = 8'h1D;
    localparam logic [7:0] GF_ALPHA = 8'h02;

    typedef enum logic [1:0] {
        OP_CTR = 2'b00,
        OP_CMAC = 2'b01,
        OP_RS = 2'b10
    } lfsc_op_t;

    function automatic logic [7:0] gf_mul(input logic [7:0] a,
                                          input logic [7:0] b);
        logic [7:0] r;
        logic [7:0] x;
        r = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++)
        begin
            if (b[i])
                r = r ^ x;
            x = {x[6:0], 1'b0} ^ (x[7] ? GF_POLY : 8'h00);
        end
        return r;
    endfunction

    // generator with roots alpha^1 .. alpha^32, monic top term implied
    function automatic logic [8*RS_PAR-1:0] rs_gen();
        logic [7:0] g [0:RS_PAR];
        logic [7:0] root;
        logic [8*RS_PAR-1:0] res;
        for (int j = 0; j <= RS_PAR; j++)
            g[j] = 8'h00;
        g[0] = 8'h01;
        root = GF_ALPHA;
        for (int i = 1; i <= RS_PAR; i++)
        begin
            for (int j = i; j >= 1; j--)
                g[j] = g[j-1] ^ gf_mul(g[j], root);
            g[0] = gf_mul(g[0], root);
            root = gf_mul(root, GF_ALPHA);
        end
        for (int j = 0; j < RS_PAR; j++)
            res[8*j +: 8] = g[j];
        return res;
    endfunction

    localparam logic [8*RS_PAR-1:0] RS_GEN = rs_gen();

endpackage

// [hw/lfsc_buf.sv]
// two-entry valid/ready output buffer
`timescale 1ns/1ps
`default_nettype none

module lfsc_buf #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [WIDTH-1:0] next_mem [0:DEPTH-1];
    logic [DEPTH-1:0] vld;
    logic [DEPTH-1:0] next_vld;

    // ==================================================
    // shift-down storage, head always in entry zero
    always_comb
    begin
        logic done;
        done = 1'b0;
        for (int i = 0; i < DEPTH; i++)
        begin
            next_mem[i] = mem[i];
            next_vld[i] = vld[i];
        end
        if (vld[0] && out_ready_i)
        begin
            for (int i = 0; i < DEPTH - 1; i++)
            begin
                next_mem[i] = mem[i+1];
                next_vld[i] = vld[i+1];
            end
            next_vld[DEPTH-1] = 1'b0;
        end
        for (int i = 0; i < DEPTH; i++)
        begin
            if (in_valid_i && !vld[DEPTH-1] && !next_vld[i] && !done)
            begin
                next_mem[i] = in_data_i;
                next_vld[i] = 1'b1;
                done = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            vld <= '0;
            for (int i = 0; i < DEPTH; i++)
                mem[i] <= '0;
        end
        else
        begin
            vld <= next_vld;
            for (int i = 0; i < DEPTH; i++)
                mem[i] <= next_mem[i];
        end
    end

    // ready is the inverted last slot valid flag, never stale
    assign in_ready_o = !vld[DEPTH-1];
    assign out_data_o = mem[0];
    assign out_valid_o = vld[0];

endmodule // lfsc_buf

`default_nettype wire

// [hw/lfsc_coder.sv]
// frame security coder: ctr keystream, cmac tag and rs(255,223) encoder
// Operation
// - download frame opens with a version byte equal to zero
// - three-byte block sequence number follows, most significant byte first
// - ciphered payload of download frame is 210 bytes, ctr encrypted
// - download tag uses the download key over header through payload
// - tag sent is leftmost four bytes of cmac, msb first
// - payload ciphered with aes-128 counter mode, same in both directions
// - exchange counter: m, a, message counter, c, zero byte, block counter
// - download counter: link header, sequence number, six zeros, counter
// - hidden 32-bit block counter starts at zero, steps by one
// - tags are aes-128 cmac
// - rs code with 8-bit symbols: 223 data plus 32 parity bytes
// - receiver decoder corrects up to sixteen bad bytes per codeword
`timescale 1ns/1ps
`default_nettype none

module lfsc_coder
    import lfsc_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic [1:0] op_i,
    input wire logic dl_mode_i,
    input wire logic [127:0] key_i,
    input wire logic [15:0] m_field_i,
    input wire logic [47:0] a_field_i,
    input wire logic [15:0] message_counter_i,
    input wire logic [7:0] c_field_i,
    input wire logic [23:0] download_link_header_i,
    input wire logic [23:0] block_sequence_number_i,
    input wire logic [7:0] in_data_i,
    input wire logic in_valid_i,
    input wire logic in_last_i,
    output logic in_ready_o,
    output logic [7:0] out_data_o,
    output logic out_valid_o,
    output logic out_last_o,
    input wire logic out_ready_i,
    output logic aes_req_o,
    output logic [127:0] aes_key_o,
    output logic [127:0] aes_blk_o,
    input wire logic aes_ack_i,
    input wire logic [127:0] aes_res_i,
    output logic busy_o
);

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_HDR = 3'b001,
        S_REQ = 3'b010,
        S_WAIT = 3'b011,
        S_DATA = 3'b100,
        S_TAG = 3'b101,
        S_PAR = 3'b110
    } lfsc_state_t;

    lfsc_state_t state, next_state;
    lfsc_op_t op, next_op;
    logic dl, next_dl;
    logic sub, next_sub;
    logic fin, next_fin;
    logic in_rdy, next_in_rdy;
    logic req, next_req;
    logic busy, next_busy;
    logic [127:0] key, next_key;
    logic [127:0] blk, next_blk;
    logic [31:0] ctr, next_ctr;
    logic [127:0] ks, next_ks;
    logic [127:0] xs, next_xs;
    logic [127:0] k1, next_k1;
    logic [127:0] k2, next_k2;
    logic [127:0] mb, next_mb;
    logic [4:0] bcnt, next_bcnt;
    logic [7:0] idx, next_idx;
    logic [7:0] par [0:RS_PAR-1];
    logic [7:0] next_par [0:RS_PAR-1];

    logic take;
    logic push_valid;
    logic [7:0] push_data;
    logic push_last;
    logic buf_rdy;
    logic [127:0] cblk;
    logic [127:0] m_full;
    logic [127:0] m_pad;
    logic [4:0] n_bytes;
    logic [7:0] fb;

    function automatic logic [127:0] dbl(input logic [127:0] x);
        return {x[126:0], 1'b0} ^ (x[127] ? {120'h0, CMAC_RB} : 128'h0);
    endfunction

    // ==================================================
    // counter block
    // download layout when dl is set, else exchange counter layout
    assign cblk = dl ? {download_link_header_i, block_sequence_number_i,
                        DL_ZERO_PAD, ctr}
                     : {m_field_i, a_field_i, message_counter_i,
                        c_field_i, STUFF_BYTE, ctr};

    // ==================================================
    // cmac block assembly
    assign take = in_valid_i && in_rdy;
    assign n_bytes = bcnt + 5'd1;
    assign m_full = {mb[119:0], in_data_i};
    // partial final block padded with one then zeros
    assign m_pad = (m_full << (8 * (BLK_BYTES - 32'(n_bytes))))
                 | ({120'h0, CMAC_PAD} << (8 * (BLK_BYTES - 1
                                                - 32'(n_bytes))));
    // parity feedback of the division register
    assign fb = in_data_i ^ par[RS_PAR-1];

    // ==================================================
    // sequencing
    always_comb
    begin
        next_state = state;
        next_op = op;
        next_dl = dl;
        next_sub = sub;
        next_fin = fin;
        next_in_rdy = 1'b0;
        next_req = req;
        next_key = key;
        next_blk = blk;
        next_ctr = ctr;
        next_ks = ks;
        next_xs = xs;
        next_k1 = k1;
        next_k2 = k2;
        next_mb = mb;
        next_bcnt = bcnt;
        next_idx = idx;
        for (int i = 0; i < RS_PAR; i++)
            next_par[i] = par[i];
        push_valid = 1'b0;
        push_data = 8'h00;
        push_last = 1'b0;
        case (state)
            S_IDLE:
            begin
                if (start_i)
                begin
                    next_op = lfsc_op_t'(op_i);
                    next_dl = dl_mode_i;
                    // key latched per operation from outside
                    next_key = key_i;
                    next_ctr = CTR_INIT;
                    next_idx = 8'h00;
                    next_bcnt = 5'd0;
                    next_xs = 128'h0;
                    next_mb = 128'h0;
                    next_fin = 1'b0;
                    next_sub = 1'b0;
                    for (int i = 0; i < RS_PAR; i++)
                        next_par[i] = 8'h00;
                    case (lfsc_op_t'(op_i))
                        OP_CTR: next_state = dl_mode_i ? S_HDR : S_REQ;
                        OP_CMAC:
                        begin
                            // subkeys come from the cipher of zero
                            next_sub = 1'b1;
                            next_state = S_REQ;
                        end
                        default: next_state = S_DATA;
                    endcase
                end
            end
            S_HDR:
            begin
                if (buf_rdy)
                begin
                    push_valid = 1'b1;
                    case (idx[1:0])
                        2'd0: push_data = DL_VERSION;
                        2'd1: push_data = block_sequence_number_i[23:16];
                        2'd2: push_data = block_sequence_number_i[15:8];
                        default: push_data = block_sequence_number_i[7:0];
                    endcase
                    next_idx = idx + 8'd1;
                    if (idx == 8'(HDR_LEN - 1))
                    begin
                        next_idx = 8'h00;
                        next_state = S_REQ;
                    end
                end
            end
            S_REQ:
            begin
                // one forward cipher call per block
                if (op == OP_CTR)
                    next_blk = cblk;
                else
                    next_blk = sub ? 128'h0 : mb;
                next_req = 1'b1;
                next_state = S_WAIT;
            end
            S_WAIT:
            begin
                if (aes_ack_i)
                begin
                    next_req = 1'b0;
                    if (op == OP_CTR)
                    begin
                        next_ks = aes_res_i;
                        next_state = S_DATA;
                    end
                    else if (sub)
                    begin
                        next_sub = 1'b0;
                        next_k1 = dbl(aes_res_i);
                        next_k2 = dbl(dbl(aes_res_i));
                        next_state = S_DATA;
                    end
                    else
                    begin
                        next_xs = aes_res_i;
                        next_state = fin ? S_TAG : S_DATA;
                    end
                end
            end
            S_DATA:
            begin
                // ready drops after each take
                next_in_rdy = (op == OP_CMAC || buf_rdy) && !take;
                if (take)
                begin
                    case (op)
                        OP_CTR:
                        begin
                            push_valid = 1'b1;
                            push_data = in_data_i ^ ks[127 - 8*idx -: 8];
                            push_last = in_last_i;
                            if (in_last_i)
                                next_state = S_IDLE;
                            else if (idx == 8'(BLK_BYTES - 1))
                            begin
                                next_idx = 8'h00;
                                next_ctr = ctr + CTR_STEP;
                                next_state = S_REQ;
                            end
                            else
                                next_idx = idx + 8'd1;
                        end
                        OP_CMAC:
                        begin
                            if (in_last_i)
                            begin
                                next_fin = 1'b1;
                                next_state = S_REQ;
                                if (n_bytes == 5'(BLK_BYTES))
                                    next_mb = xs ^ m_full ^ k1;
                                else
                                    next_mb = xs ^ m_pad ^ k2;
                            end
                            else if (n_bytes == 5'(BLK_BYTES))
                            begin
                                next_mb = xs ^ m_full;
                                next_bcnt = 5'd0;
                                next_state = S_REQ;
                            end
                            else
                            begin
                                next_mb = m_full;
                                next_bcnt = n_bytes;
                            end
                        end
                        default:
                        begin
                            push_valid = 1'b1;
                            push_data = in_data_i;
                            for (int i = RS_PAR - 1; i > 0; i--)
                                next_par[i] = par[i-1]
                                            ^ gf_mul(fb, RS_GEN[8*i +: 8]);
                            next_par[0] = gf_mul(fb, RS_GEN[7:0]);
                            next_idx = idx + 8'd1;
                            if (idx == 8'(RS_K - 1))
                            begin
                                next_idx = 8'h00;
                                next_state = S_PAR;
                            end
                        end
                    endcase
                end
            end
            S_TAG:
            begin
                if (buf_rdy)
                begin
                    push_valid = 1'b1;
                    push_data = xs[127 - 8*idx -: 8];
                    push_last = idx == 8'(TAG_BYTES - 1);
                    next_idx = idx + 8'd1;
                    if (push_last)
                        next_state = S_IDLE;
                end
            end
            S_PAR:
            begin
                if (buf_rdy)
                begin
                    push_valid = 1'b1;
                    push_data = par[RS_PAR-1];
                    for (int i = RS_PAR - 1; i > 0; i--)
                        next_par[i] = par[i-1];
                    next_par[0] = 8'h00;
                    push_last = idx == 8'(RS_PAR - 1);
                    next_idx = idx + 8'd1;
                    if (push_last)
                        next_state = S_IDLE;
                end
            end
            default: next_state = S_IDLE;
        endcase
        next_busy = next_state != S_IDLE;
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state <= S_IDLE;
            op <= OP_CTR;
            dl <= 1'b0;
            sub <= 1'b0;
            fin <= 1'b0;
            in_rdy <= 1'b0;
            req <= 1'b0;
            busy <= 1'b0;
            key <= 128'h0;
            blk <= 128'h0;
            ctr <= CTR_INIT;
            ks <= 128'h0;
            xs <= 128'h0;
            k1 <= 128'h0;
            k2 <= 128'h0;
            mb <= 128'h0;
            bcnt <= 5'd0;
            idx <= 8'h00;
            for (int i = 0; i < RS_PAR; i++)
                par[i] <= 8'h00;
        end
        else
        begin
            state <= next_state;
            op <= next_op;
            dl <= next_dl;
            sub <= next_sub;
            fin <= next_fin;
            in_rdy <= next_in_rdy;
            req <= next_req;
            busy <= next_busy;
            key <= next_key;
            blk <= next_blk;
            ctr <= next_ctr;
            ks <= next_ks;
            xs <= next_xs;
            k1 <= next_k1;
            k2 <= next_k2;
            mb <= next_mb;
            bcnt <= next_bcnt;
            idx <= next_idx;
            for (int i = 0; i < RS_PAR; i++)
                par[i] <= next_par[i];
        end
    end

    // ==================================================
    // output buffer, a receiver stall loses no byte
    lfsc_buf #(
        .WIDTH(9),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .in_data_i({push_last, push_data}),
        .in_valid_i(push_valid),
        .in_ready_o(buf_rdy),
        .out_data_o({out_last_o, out_data_o}),
        .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i)
    );

    assign in_ready_o = in_rdy;
    assign aes_req_o = req;
    assign aes_key_o = key;
    assign aes_blk_o = blk;
    assign busy_o = busy;

endmodule // lfsc_coder

`default_nettype wire

// [verif/lfsc_aes_model.sv]
// behavioural stand-in for the external aes-128 core
`timescale 1ns/1ps
`default_nettype none

module lfsc_aes_model (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic req_i,
    input wire logic [127:0] key_i,
    input wire logic [127:0] blk_i,
    input wire logic slow_i,
    output logic ack_o,
    output logic [127:0] res_o
);
    // ==================================================
    // answer
    logic [3:0] wait_cnt;

    // one forward cipher; xor stand-in keeps bench maths short
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ack_o <= 1'b0;
            res_o <= '0;
            wait_cnt <= 4'h0;
        end
        else if (req_i && !ack_o && wait_cnt >= (slow_i ? 4'h5 : 4'h0))
        begin
            ack_o <= 1'b1;
            res_o <= blk_i ^ key_i;
            wait_cnt <= 4'h0;
        end
        else
        begin
            ack_o <= 1'b0;
            // result not held after the ack pulse
            res_o <= ~res_o;
            wait_cnt <= (req_i && !ack_o) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule // lfsc_aes_model

`default_nettype wire

// [verif/lfsc_coder_assertions.sv]
// port checker for the frame security coder
`timescale 1ns/1ps
`default_nettype none

module lfsc_coder_chk
    import lfsc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic [1:0] op_i,
    input wire logic dl_mode_i,
    input wire logic in_valid_i,
    input wire logic in_ready_o,
    input wire logic [7:0] out_data_o,
    input wire logic out_valid_o,
    input wire logic out_last_o,
    input wire logic out_ready_i,
    input wire logic aes_req_o,
    input wire logic [127:0] aes_key_o,
    input wire logic [127:0] aes_blk_o,
    input wire logic aes_ack_i,
    input wire logic busy_o
);
    // ==================================================
    // helper state
    logic [1:0] op_q, next_op;
    logic dl_q, next_dl, first_q, next_first;
    logic [127:0] prev_blk, next_prev;
    logic [8:0] ocnt, next_cnt;
    logic take;

    assign take = out_valid_o && out_ready_i;
    always_comb
    begin
        next_op = op_q;
        next_dl = dl_q;
        next_first = first_q;
        next_prev = prev_blk;
        next_cnt = take ? ocnt + 9'h001 : ocnt;
        if (aes_req_o && aes_ack_i)
        begin
            next_first = 1'b0;
            next_prev = aes_blk_o;
        end
        if (start_i && !busy_o)
        begin
            next_op = op_i;
            next_dl = dl_mode_i;
            next_first = 1'b1;
            next_cnt = 9'h000;
        end
    end
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            op_q <= 2'h3;
            dl_q <= 1'b0;
            first_q <= 1'b1;
            prev_blk <= '0;
            ocnt <= 9'h000;
        end
        else
        begin
            op_q <= next_op;
            dl_q <= next_dl;
            first_q <= next_first;
            prev_blk <= next_prev;
            ocnt <= next_cnt;
        end
    end

    // ==================================================
    // assertions
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    chk_req_hold: assert property (aes_req_o && !aes_ack_i |=>
        aes_req_o && $stable(aes_blk_o)) else $error("aes block moved");
    chk_key_hold: assert property (aes_req_o && !aes_ack_i |=>
        $stable(aes_key_o)) else $error("aes key moved");
    chk_ctr_first: assert property ($rose(aes_req_o) && op_q == OP_CTR
        && first_q |-> aes_blk_o[31:0] == CTR_INIT) else $error("bad ctr0");
    chk_ctr_step: assert property ($rose(aes_req_o) && op_q == OP_CTR
        && !first_q |-> aes_blk_o == {prev_blk[127:32],
        prev_blk[31:0] + CTR_STEP}) else $error("bad counter step");
    chk_dl_pad: assert property ($rose(aes_req_o) && op_q == OP_CTR
        && dl_q |-> aes_blk_o[79:32] == DL_ZERO_PAD) else $error("pad");
    chk_ex_stuff: assert property ($rose(aes_req_o) && op_q == OP_CTR
        && !dl_q |-> aes_blk_o[39:32] == STUFF_BYTE) else $error("stuff");
    chk_out_hold: assert property (out_valid_o && !out_ready_i |=>
        out_valid_o && $stable(out_data_o) && $stable(out_last_o))
        else $error("output moved");
    chk_in_gap: assert property (in_valid_i && in_ready_o |=>
        !in_ready_o) else $error("ready right after take");
    chk_rs_len: assert property (take && out_last_o && op_q == OP_RS
        |-> ocnt == 9'(RS_N - 1)) else $error("codeword length");
    chk_tag_len: assert property (take && out_last_o && op_q == OP_CMAC
        |-> ocnt == 9'(TAG_BYTES - 1)) else $error("tag length");

    cover property (take && out_last_o && op_q == OP_CTR && dl_q);
    cover property (take && out_last_o && op_q == OP_CMAC);
    cover property (take && out_last_o && op_q == OP_RS);
endmodule // lfsc_coder_chk

bind lfsc_coder lfsc_coder_chk u_chk (.*);

`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the frame security coder
`timescale 1ns/1ps
`default_nettype none

module testbench
    import lfsc_pkg::*;
;
    logic sys_clk_i = 0, rstn_i = 0, start_i = 0, dl_mode_i = 0;
    logic in_valid_i = 0, in_last_i = 0, out_ready_i = 1, stall = 0;
    logic slow = 0, in_ready_o, out_valid_o, out_last_o, aes_req_o;
    logic aes_ack_i, busy_o;
    logic [1:0] op_i = 2'h0;
    logic [7:0] in_data_i = 8'h00, out_data_o;
    logic [127:0] key_i = {16{8'hA5}};
    logic [127:0] aes_key_o, aes_blk_o, aes_res_i;
    logic [15:0] m_fld = 16'hA1B2, msg_cnt = 16'h0102;
    logic [47:0] a_fld = 48'h1122_3344_5566;
    logic [7:0] c_fld = 8'h44;
    logic [23:0] hdr = 24'hC0FFEE, seq = 24'h01A2B3;
    logic [7:0] outq[$];
    logic lastq[$];
    logic [127:0] blkq[$];
    int n_fail = 0, checks_done = 0, cyc = 0;

    lfsc_coder u_dut (.*, .m_field_i(m_fld), .a_field_i(a_fld),
        .message_counter_i(msg_cnt), .c_field_i(c_fld),
        .download_link_header_i(hdr), .block_sequence_number_i(seq));
    lfsc_aes_model u_aes (.*,
        .req_i(aes_req_o), .key_i(aes_key_o), .blk_i(aes_blk_o),
        .slow_i(slow), .ack_o(aes_ack_i), .res_o(aes_res_i));

    // ==================================================
    // clock, capture, helpers
    always #10 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (out_valid_o && out_ready_i)
        begin
            outq.push_back(out_data_o);
            lastq.push_back(out_last_o);
        end
        if (aes_req_o && aes_ack_i)
            blkq.push_back(aes_blk_o);
        out_ready_i <= stall ? (cyc % 3 != 0) : 1'b1;
    end

    task automatic check(input logic [127:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic go(input logic [1:0] op, input logic dl);
        @(posedge sys_clk_i);
        outq.delete();
        lastq.delete();
        blkq.delete();
        start_i <= 1'b1;
        op_i <= op;
        dl_mode_i <= dl;
        @(posedge sys_clk_i);
        start_i <= 1'b0;
    endtask

    task automatic feed(input int n, input logic [7:0] b0);
        for (int i = 0; i < n; i++)
        begin
            in_valid_i <= 1'b1;
            in_data_i <= 8'(b0 + i * 13);
            in_last_i <= (i == n - 1);
            do @(posedge sys_clk_i); while (in_ready_o !== 1'b1);
        end
        in_valid_i <= 1'b0;
        in_last_i <= 1'b0;
    endtask

    task automatic drain(input int n);
        for (int k = 0; k < 4000 && outq.size() < n; k++)
            @(posedge sys_clk_i);
        repeat (4) @(posedge sys_clk_i);
        check(outq.size(), n);
        check(lastq[n - 1], 1'b1);
    endtask

    function automatic logic [7:0] ksb(input logic [95:0] hi, input int j);
        logic [127:0] e;
        e = {hi, 32'(j / 16)} ^ key_i;
        return e[127 - 8 * (j % 16) -: 8];
    endfunction

    task automatic ctr_check(input logic [95:0] hi, input int pre,
                             input int n, input logic [7:0] b0);
        check(blkq.size(), (n + 15) / 16);
        foreach (blkq[k])
            check(blkq[k], {hi, 32'(k)});
        for (int i = 0; i < n; i++)
            check(outq[pre + i], 8'(b0 + i * 13) ^ ksb(hi, i));
    endtask

    // ==================================================
    // scenarios
    task automatic ctr_exchange();
        slow = 1;
        go(OP_CTR, 1'b0);
        feed(20, 8'h11);
        drain(20);
        ctr_check({m_fld, a_fld, msg_cnt, c_fld, STUFF_BYTE}, 0, 20, 8'h11);
        slow = 0;
    endtask

    task automatic ctr_download();
        go(OP_CTR, 1'b1);
        feed(PAYLOAD_LEN, 8'h40);
        drain(HDR_LEN + PAYLOAD_LEN);
        check(outq[0], DL_VERSION);
        check({outq[1], outq[2], outq[3]}, seq);
        ctr_check({hdr, seq, DL_ZERO_PAD}, 4, PAYLOAD_LEN, 8'h40);
    endtask

    task automatic cmac_tag();
        logic [127:0] msg, k1, tag;
        for (int i = 0; i < 16; i++)
            msg[127 - 8 * i -: 8] = 8'(8'h20 + i * 13);
        k1 = {key_i[126:0], 1'b0} ^ (key_i[127] ? {120'h0, CMAC_RB} : 128'h0);
        tag = msg ^ k1 ^ key_i;
        go(OP_CMAC, 1'b1);
        feed(BLK_BYTES, 8'h20);
        drain(TAG_BYTES);
        check({outq[0], outq[1], outq[2], outq[3]}, tag[127:96]);
    endtask

    task automatic rs_encode();
        logic [7:0] s, a;
        stall = 1;
        go(OP_RS, 1'b0);
        feed(RS_K, 8'h05);
        drain(RS_N);
        for (int i = 0; i < RS_K; i++)
            check(outq[i], 8'(8'h05 + i * 13));
        a = 8'h01;
        repeat (RS_PAR)
        begin
            a = gf_mul(a, GF_ALPHA);
            s = 8'h00;
            foreach (outq[i])
                s = gf_mul(s, a) ^ outq[i];
            check(s, 8'h00);
        end
    endtask

    // ==================================================
    // sequence and verdict
    task automatic summarize();
        $display("n_fail=%0d checks_done=%0d", n_fail, checks_done);
        if (n_fail == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (6) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        ctr_exchange();
        ctr_download();
        cmac_tag();
        rs_encode();
        summarize();
    end

    // the run needs about 1100 cycles
    initial
    begin
        repeat (30000) @(posedge sys_clk_i);
        n_fail++;
        summarize();
    end
endmodule // testbench

`default_nettype wire
